// >>> wdk_pkg.sv
// package: constants, types and register map of the sleep-kill watchdog
`default_nettype none
package wdk_pkg;
   // --------------------------------------------------------------
   // register map (printed offset is a word index, byte addr = 4x)
   // --------------------------------------------------------------
   localparam int          WDK_ADDR_W   = 12;
   localparam logic [9:0]  WDK_CSR_IDX  = 10'h036;
   localparam logic [9:0]  WDK_STAT_IDX = 10'h037;
   localparam logic [9:0]  WDK_MASK_IDX = 10'h038;
   localparam logic [11:0] WDK_CSR_ADDR  = {WDK_CSR_IDX, 2'b00};
   localparam logic [11:0] WDK_STAT_ADDR = {WDK_STAT_IDX, 2'b00};
   localparam logic [11:0] WDK_MASK_ADDR = {WDK_MASK_IDX, 2'b00};
   // control/status field positions
   localparam int WDK_EN_BIT   = 7;
   localparam int WDK_KILL_BIT = 6;
   localparam int WDK_FLAG_BIT = 5;
   localparam int WDK_SEL_HI   = 1;
   localparam int WDK_SEL_LO   = 0;
   localparam logic [7:0] WDK_CSR_RESET = 8'h00;
   // interrupt event bits
   localparam int         WDK_EV_W      = 2;
   localparam int         WDK_EV_EXPIRY = 0;
   localparam int         WDK_EV_KICK   = 1;
   localparam logic [1:0] WDK_EV_RESET  = 2'h0;
   // --------------------------------------------------------------
   // timing: 4 Hz tick from the 125 MHz clock
   // --------------------------------------------------------------
   localparam int WDK_CLK_HZ   = 125_000_000;
   localparam int WDK_TICK_MS  = 250;
   localparam int WDK_TICK_CYC = WDK_CLK_HZ / 1000 * WDK_TICK_MS;
   // ticks per period select: 2, 4, 8, 16 quarter seconds
   localparam logic [4:0] WDK_LOAD_00 = 5'h02;
   localparam logic [4:0] WDK_LOAD_01 = 5'h04;
   localparam logic [4:0] WDK_LOAD_10 = 5'h08;
   localparam logic [4:0] WDK_LOAD_11 = 5'h10;
   // --------------------------------------------------------------
   // types
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      WDK_KS_FRESH   = 2'b00,
      WDK_KS_OFF     = 2'b01,
      WDK_KS_ARMED   = 2'b10,
      WDK_KS_ENGAGED = 2'b11
   } wdk_kill_e;
   typedef struct packed {
      logic        sel;
      logic        en;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } wdk_apb_s;
endpackage : wdk_pkg
`default_nettype wire

// >>> wdk_watchdog.sv
// top: sleep-kill watchdog with apb register access and interrupt
//
// Chosen here: the APB slave port.
`default_nettype none
// Behaviour
// - flag reads 1 after expiry, 0 otherwise
// - reading control/status clears the flag
// - writing 0 to flag clears it
// - writing 1 to flag reloads counter only
// - enable resets 0; writing 1 loads, starts
// - counter reaching zero resets system, sets flag
// - enable sticks until reset; writing 0 ignored
// - only first write with kill 1 arms
// - second write with kill 0 engages
// - engaged sleep reloads counter, blocks resets
// - counting resumes once sleep ends
// - kill reads first written value, else 0
// - select 00/01/10/11 gives 0.5/1/2/4 s
// - counter steps on a 4 Hz tick
module wdk_watchdog #(
   parameter int TICK_CYC = wdk_pkg::WDK_TICK_CYC
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic        pready,
   output var  logic [31:0] prdata,
   output var  logic        pslverr,
   input  wire logic        sleep_req,
   output var  logic        wdog_rst,
   output var  logic        wdog_active,
   output var  logic        irq
);
   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wdk_pkg::wdk_apb_s apb;
   logic              pready_ff;
   logic [31:0]       prdata_ff;
   logic              pslverr_ff;
   logic              nxt_pready;
   logic [31:0]       nxt_prdata;
   logic              nxt_pslverr;
   logic              acc;
   logic              hit_csr;
   logic              hit_stat;
   logic              hit_mask;
   logic              csr_wr;
   logic              csr_rd;

   assign apb      = '{sel: psel, en: penable, write: pwrite, addr: paddr, wdata: pwdata};
   // a transfer completes only at the edge where pready is high
   assign acc      = apb.sel & apb.en & pready_ff;
   assign hit_csr  = apb.addr == wdk_pkg::WDK_CSR_ADDR;
   assign hit_stat = apb.addr == wdk_pkg::WDK_STAT_ADDR;
   assign hit_mask = apb.addr == wdk_pkg::WDK_MASK_ADDR;
   assign csr_wr   = acc & apb.write & hit_csr;
   assign csr_rd   = acc & !apb.write & hit_csr;

   // ---------------------------------------------------------------
   // watchdog core state
   // ---------------------------------------------------------------
   logic                en_ff, nxt_en;
   logic                kill_rd_ff, nxt_kill_rd;
   logic                flag_ff, nxt_flag;
   logic [1:0]          sel_ff, nxt_sel;
   wdk_pkg::wdk_kill_e  ks_ff, nxt_ks;
   logic [4:0]          wcnt_ff, nxt_wcnt;
   logic [24:0]         pre_ff, nxt_pre;
   logic                rst_ff, nxt_rst;
   logic                tick;
   logic                kill_sleep;
   logic                expire;
   logic                kick;
   logic [7:0]          csr_val;

   // period decode, shared by enable and service reloads
   function automatic logic [4:0] load_of(input logic [1:0] s);
      case (s)
         2'b00:   load_of = wdk_pkg::WDK_LOAD_00;
         2'b01:   load_of = wdk_pkg::WDK_LOAD_01;
         2'b10:   load_of = wdk_pkg::WDK_LOAD_10;
         default: load_of = wdk_pkg::WDK_LOAD_11;
      endcase
   endfunction

   // prescaler runs free outside engaged sleep, so the first tick lands anywhere in 0..250 ms
   assign tick       = pre_ff == 25'h0;
   assign kill_sleep = (ks_ff == wdk_pkg::WDK_KS_ENGAGED) & sleep_req;
   assign expire     = en_ff & tick & (wcnt_ff == 5'h01) & !kill_sleep;
   assign kick       = csr_wr & apb.wdata[wdk_pkg::WDK_FLAG_BIT] & en_ff;
   assign csr_val    = {en_ff, kill_rd_ff, flag_ff, 3'h0, sel_ff};

   // next state of the counter, enable, flag and kill sequence
   always_comb
   begin
      nxt_en      = en_ff;
      nxt_kill_rd = kill_rd_ff;
      nxt_flag    = flag_ff;
      nxt_sel     = sel_ff;
      nxt_ks      = ks_ff;
      nxt_wcnt    = wcnt_ff;
      nxt_rst     = 1'b0;
      nxt_pre     = tick ? 25'(TICK_CYC - 1) : pre_ff - 25'h1;
      if (en_ff && tick)
      begin
         nxt_wcnt = wcnt_ff - 5'h1;
      end
      if (csr_rd)
      begin
         nxt_flag = 1'b0;
      end
      if (csr_wr)
      begin
         nxt_sel = apb.wdata[wdk_pkg::WDK_SEL_HI:wdk_pkg::WDK_SEL_LO];
         // only a 1 acts on enable, so a stray 0 cannot stop the dog
         if (apb.wdata[wdk_pkg::WDK_EN_BIT])
         begin
            nxt_en   = 1'b1;
            nxt_wcnt = load_of(nxt_sel);
         end
         if (!apb.wdata[wdk_pkg::WDK_FLAG_BIT])
         begin
            nxt_flag = 1'b0;
         end
         else if (en_ff)
         begin
            nxt_wcnt = load_of(nxt_sel);
         end
         // two distinct writes needed so one stray write cannot engage
         case (ks_ff)
            wdk_pkg::WDK_KS_FRESH:
            begin
               nxt_kill_rd = apb.wdata[wdk_pkg::WDK_KILL_BIT];
               nxt_ks = apb.wdata[wdk_pkg::WDK_KILL_BIT] ? wdk_pkg::WDK_KS_ARMED
                                                         : wdk_pkg::WDK_KS_OFF;
            end
            wdk_pkg::WDK_KS_ARMED:
            begin
               nxt_ks = apb.wdata[wdk_pkg::WDK_KILL_BIT] ? wdk_pkg::WDK_KS_OFF
                                                         : wdk_pkg::WDK_KS_ENGAGED;
            end
            default:
            begin
               nxt_ks = ks_ff;
            end
         endcase
      end
      if (kill_sleep)
      begin
         nxt_wcnt = load_of(sel_ff);
         nxt_pre  = 25'(TICK_CYC - 1);
      end
      // expiry acts as a reset of this block, flag set wins over clears
      if (expire)
      begin
         nxt_en      = 1'b0;
         nxt_kill_rd = 1'b0;
         nxt_sel     = 2'h0;
         nxt_ks      = wdk_pkg::WDK_KS_FRESH;
         nxt_wcnt    = wdk_pkg::WDK_LOAD_00;
         nxt_flag    = 1'b1;
         nxt_rst     = 1'b1;
      end
   end

   // core registers, power-on reset leaves flag at 0
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         en_ff      <= wdk_pkg::WDK_CSR_RESET[wdk_pkg::WDK_EN_BIT];
         kill_rd_ff <= wdk_pkg::WDK_CSR_RESET[wdk_pkg::WDK_KILL_BIT];
         flag_ff    <= wdk_pkg::WDK_CSR_RESET[wdk_pkg::WDK_FLAG_BIT];
         sel_ff     <= wdk_pkg::WDK_CSR_RESET[wdk_pkg::WDK_SEL_HI:wdk_pkg::WDK_SEL_LO];
         ks_ff      <= wdk_pkg::WDK_KS_FRESH;
         wcnt_ff    <= wdk_pkg::WDK_LOAD_00;
         pre_ff     <= 25'h0;
         rst_ff     <= 1'b0;
      end
      else
      begin
         en_ff      <= nxt_en;
         kill_rd_ff <= nxt_kill_rd;
         flag_ff    <= nxt_flag;
         sel_ff     <= nxt_sel;
         ks_ff      <= nxt_ks;
         wcnt_ff    <= nxt_wcnt;
         pre_ff     <= nxt_pre;
         rst_ff     <= nxt_rst;
      end
   end

   // ---------------------------------------------------------------
   // interrupt status and mask
   // ---------------------------------------------------------------
   logic [1:0] stat_ff, nxt_stat;
   logic [1:0] mask_ff, nxt_mask;
   logic       irq_ff, nxt_irq;

   // read clears status; an event in the same cycle still sets
   always_comb
   begin
      nxt_stat = (acc && !apb.write && hit_stat) ? 2'h0 : stat_ff;
      nxt_stat[wdk_pkg::WDK_EV_EXPIRY] = nxt_stat[wdk_pkg::WDK_EV_EXPIRY] | expire;
      nxt_stat[wdk_pkg::WDK_EV_KICK]   = nxt_stat[wdk_pkg::WDK_EV_KICK] | kick;
      nxt_mask = (acc && apb.write && hit_mask) ? apb.wdata[1:0] : mask_ff;
      nxt_irq  = |(stat_ff & mask_ff);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         stat_ff <= wdk_pkg::WDK_EV_RESET;
         mask_ff <= wdk_pkg::WDK_EV_RESET;
         irq_ff  <= 1'b0;
      end
      else
      begin
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         irq_ff  <= nxt_irq;
      end
   end

   // ---------------------------------------------------------------
   // apb answer: one wait-free access phase after each setup
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_pready  = apb.sel & !apb.en;
      nxt_prdata  = 32'h0;
      nxt_pslverr = 1'b0;
      if (apb.sel && !apb.en)
      begin
         if (hit_csr)
         begin
            nxt_prdata = {24'h0, csr_val};
         end
         else if (hit_stat)
         begin
            nxt_prdata = {30'h0, stat_ff};
         end
         else if (hit_mask)
         begin
            nxt_prdata = {30'h0, mask_ff};
         end
         else
         begin
            nxt_pslverr = 1'b1; // unmapped: error, reads zero
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff  <= nxt_pready;
         prdata_ff  <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign pready      = pready_ff;
   assign prdata      = prdata_ff;
   assign pslverr     = pslverr_ff;
   assign wdog_rst    = rst_ff;
   assign wdog_active = en_ff;
   assign irq         = irq_ff;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_expiry_flag: assert property (rst_ff |-> flag_ff && !en_ff)
      else $error("expiry reset without flag");
   a_por_clear: assert property ($past(srst) |-> !flag_ff && !en_ff)
      else $error("flag or enable set after power-on reset");
   a_read_clears: assert property (csr_rd && !expire |=> !flag_ff)
      else $error("read did not clear flag");
   a_write0_clears: assert property (csr_wr && !pwdata[5] && !expire |=> !flag_ff)
      else $error("write 0 did not clear flag");
   a_kick_reload: assert property (kick && !expire && !kill_sleep
      |=> wcnt_ff == load_of($past(pwdata[1:0])) && flag_ff == $past(flag_ff))
      else $error("service write did not reload");
   a_enable_load: assert property (csr_wr && pwdata[7] && !expire && !kill_sleep
      |=> en_ff && wcnt_ff == load_of($past(pwdata[1:0])))
      else $error("enable write did not load counter");
   a_enable_sticky: assert property (en_ff && !expire |=> en_ff)
      else $error("enable dropped without reset");
   a_arm_first: assert property (ks_ff == wdk_pkg::WDK_KS_FRESH && csr_wr && !expire
      |=> ks_ff == (pwdata[6] ? wdk_pkg::WDK_KS_ARMED : wdk_pkg::WDK_KS_OFF))
      else $error("first write did not set kill sequence");
   a_engage_path: assert property (ks_ff == wdk_pkg::WDK_KS_ENGAGED
      |-> $past(ks_ff) inside {wdk_pkg::WDK_KS_ARMED, wdk_pkg::WDK_KS_ENGAGED})
      else $error("kill engaged without arming");
   a_sleep_quiet: assert property (kill_sleep [*2] |-> !rst_ff ##1 !rst_ff)
      else $error("reset during engaged sleep");
   a_count_step: assert property (en_ff && tick && !kill_sleep && !csr_wr
      && wcnt_ff > 5'h01 |=> wcnt_ff == $past(wcnt_ff) - 5'h01)
      else $error("counter did not step on tick");
   a_kill_read: assert property (csr_wr && ks_ff == wdk_pkg::WDK_KS_FRESH && !expire
      |=> kill_rd_ff == $past(pwdata[6]))
      else $error("kill read value not first write");

   c_expiry: cover property (rst_ff);
   c_engaged_sleep: cover property (kill_sleep ##1 !sleep_req);
   c_kick: cover property (kick ##1 !flag_ff);
   c_irq: cover property (irq_ff);

endmodule // wdk_watchdog
`default_nettype wire

// >>> tb_top.sv
// testbench: register, sleep-kill and expiry scenarios for the watchdog
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // --------------------------------------------------------------
   // signals and design
   // --------------------------------------------------------------
   localparam int TK = 8; // short tick keeps the run brief
   logic        clk       = 1'b0;
   logic        srst      = 1'b1;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [11:0] paddr     = 12'h000;
   logic [31:0] pwdata    = 32'h0;
   logic        sleep_req = 1'b0;
   logic        pready, pslverr, wdog_rst, wdog_active, irq;
   logic [31:0] prdata;
   int          bad_count = 0;
   int          n_tests   = 0;
   int          rst_count = 0;
   int          cyc       = 0;
   wdk_watchdog #(.TICK_CYC(TK)) i_wdk_watchdog (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .sleep_req(sleep_req), .wdog_rst(wdog_rst),
      .wdog_active(wdog_active), .irq(irq));
   // --------------------------------------------------------------
   // clock, reset pulse counter, timeout
   // --------------------------------------------------------------
   initial
   begin
      forever #4 clk = ~clk;
   end
   // counted at the falling edge, where registered outputs are settled
   always @(negedge clk)
   begin
      if (wdog_rst === 1'b1) rst_count++;
      cyc++;
      if (cyc == 6000)
      begin
         bad_count++;
         print_verdict();
      end
   end
   // --------------------------------------------------------------
   // shared tasks
   // --------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask
   // one apb transfer; waits for pready with no assumed latency
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // request stands until the rising edge that samples pready high
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      chk({31'h0, pready}, 32'h1, "pready timeout");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp, "read data");
      chk({31'h0, e}, {31'h0, experr}, "slave error");
   endtask
   // cycles until the reset request pulse, bounded
   task automatic wait_rst(output int n);
      n = 0;
      while (wdog_rst !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic chk_span(input int n, input int ticks);
      chk({31'h0, (n >= (ticks - 1) * TK - 2) && (n <= ticks * TK + 3)}, 32'h1, "timeout span");
   endtask
   task automatic do_reset();
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
   endtask
   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic t_reset_vals();
      rd(wdk_pkg::WDK_CSR_ADDR, 32'h0, 1'b0);
      rd(wdk_pkg::WDK_STAT_ADDR, 32'h0, 1'b0);
      rd(wdk_pkg::WDK_MASK_ADDR, 32'h0, 1'b0);
      rd(12'h100, 32'h0, 1'b1);
      chk({31'h0, wdog_active}, 32'h0, "active after reset");
      $display("test reset_vals done");
   endtask
   // arm then engage kill; sleep must hold off expiry past the period
   task automatic t_sleep_kill();
      int n;
      wr(wdk_pkg::WDK_CSR_ADDR, 32'h43);
      wr(wdk_pkg::WDK_CSR_ADDR, 32'h83);
      sleep_req <= 1'b1;
      rd(wdk_pkg::WDK_CSR_ADDR, 32'hc3, 1'b0);
      n = rst_count;
      repeat (200) @(posedge clk);
      chk(rst_count, n, "no reset while asleep");
      sleep_req <= 1'b0;
      wait_rst(n);
      chk_span(n, 16);
      repeat (2) @(posedge clk);
      chk({31'h0, wdog_active}, 32'h0, "disabled by expiry");
      rd(wdk_pkg::WDK_CSR_ADDR, 32'h20, 1'b0);
      rd(wdk_pkg::WDK_CSR_ADDR, 32'h0, 1'b0);
      $display("test sleep_kill done");
   endtask
   // every period select, sleep held high but kill never engaged
   task automatic t_periods();
      int n;
      int ticks [4] = '{2, 4, 8, 16};
      sleep_req <= 1'b1;
      for (int s = 0; s < 4; s++)
      begin
         wr(wdk_pkg::WDK_CSR_ADDR, 32'h80 | s);
         wait_rst(n);
         chk_span(n, ticks[s]);
         @(posedge clk);
      end
      sleep_req <= 1'b0;
      wr(wdk_pkg::WDK_CSR_ADDR, 32'h0);
      rd(wdk_pkg::WDK_CSR_ADDR, 32'h0, 1'b0);
      $display("test periods done");
   endtask
   // service writes keep it alive; disable ignored; interrupts
   task automatic t_service();
      int n;
      wr(wdk_pkg::WDK_MASK_ADDR, 32'h2);
      wr(wdk_pkg::WDK_CSR_ADDR, 32'h81);
      wr(wdk_pkg::WDK_CSR_ADDR, 32'h0);
      chk({31'h0, wdog_active}, 32'h1, "enable sticks");
      n = rst_count;
      repeat (6)
      begin
         repeat (14) @(posedge clk);
         wr(wdk_pkg::WDK_CSR_ADDR, 32'ha1);
      end
      chk(rst_count, n, "service prevents expiry");
      rd(wdk_pkg::WDK_CSR_ADDR, 32'h81, 1'b0);
      chk({31'h0, irq}, 32'h1, "kick irq");
      // expiry bit is sticky from the earlier scenarios' time-outs
      rd(wdk_pkg::WDK_STAT_ADDR, 32'h3, 1'b0);
      wr(wdk_pkg::WDK_MASK_ADDR, 32'h1);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      rd(wdk_pkg::WDK_MASK_ADDR, 32'h1, 1'b0);
      // reload with a new select right before timing the expiry
      wr(wdk_pkg::WDK_CSR_ADDR, 32'h82);
      wait_rst(n);
      chk_span(n, 8);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1, "expiry irq");
      rd(wdk_pkg::WDK_STAT_ADDR, 32'h1, 1'b0);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "irq after read");
      do_reset();
      rd(wdk_pkg::WDK_CSR_ADDR, 32'h0, 1'b0);
      rd(wdk_pkg::WDK_MASK_ADDR, 32'h0, 1'b0);
      $display("test service done");
   endtask
   // --------------------------------------------------------------
   // verdict and main sequence
   // --------------------------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      do_reset();
      t_reset_vals();
      t_sleep_kill();
      t_periods();
      t_service();
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
